// ### verilog/tape_read_byte_assembly.sv
// Tape read byte assembly: strobe processing, data buffer, bus gating, AXI4-Lite registers
//
// Contract
// - Pass grant when master or not requesting
// - Char strobe per read strobe, check gated
// - Char strobe sets select-read flip-flop
// - Nine-track gates channels into buffer bits
// - Buffer halves loaded by separate strobes
// - Normal modes load both halves together
// - Address bit zero picks bus byte
// - Read lines reversed into channel order
// - Seven-track blocks channels six and seven
// - Nibble-pack needs seven-track selected
// - First nibble character loads both halves
// - Second nibble character loads upper half
// - Nibble-pack requests DMA after even characters
// - Processor read returns buffer and parity
// - Even logic passes only odd strobes
// - Phase toggles each strobe when writing
// - Launch or clear presets both flip-flops
// - Strobe toggles even, switch takes new value same edge
// - Outside nibble-pack every strobe passes
// - Request enabled by even character phase
// - No request on check character strobes
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module tape_read_byte_assembly (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // AXI4-Lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [tape_rd_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // AXI4-Lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [tape_rd_pkg::AXI_DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // AXI4-Lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // AXI4-Lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [tape_rd_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // AXI4-Lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [tape_rd_pkg::AXI_DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // Tape transport pins
  input wire logic [7:0] TRANSPORT_READ_LINES,
  input wire logic TRANSPORT_READ_STROBE,
  input wire logic TRANSPORT_WRITE_STROBE,
  input wire logic CHECK_CHAR_STROBE,
  input wire logic CYCLIC_CHECK_STROBE,
  input wire logic CHECK_CHAR_PARITY,
  input wire logic GENERAL_CLEAR,
  // DMA side
  input wire logic DMA_GRANT_IN,
  output logic DMA_GRANT_OUT,
  input wire logic DMA_MASTER_ACTIVE,
  input wire logic DMA_DATA_PHASE,
  input wire logic DMA_CYCLE_DONE,
  input wire logic MEM_ADDR_BIT0,
  output logic DMA_REQUEST,
  // System bus data lines
  output logic [15:0] BUS_DATA,
  output logic BUS_DATA_OE
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [tape_rd_pkg::SYNC_W-1:0] sync1;
    logic [tape_rd_pkg::SYNC_W-1:0] sync2;
    logic rd_prev;
    logic wr_prev;
    logic chk_seen;
    logic crc_seen;
    logic [tape_rd_pkg::CTRL_W-1:0] ctrl;
    logic select_read;
    logic [tape_rd_pkg::BUF_W-1:0] buffer;
    logic parity;
    logic req_pend;
    logic dma_request;
    logic [15:0] bus_data;
    logic bus_oe;
    logic aw_have;
    logic [tape_rd_pkg::AXI_ADDR_W-1:0] awaddr;
    logic w_have;
    logic [tape_rd_pkg::AXI_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [tape_rd_pkg::AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } path_state_t;

  localparam path_state_t PATH_RESET = '{
    ctrl: tape_rd_pkg::CTRL_RESET,
    bresp: tape_rd_pkg::RESP_OKAY,
    rresp: tape_rd_pkg::RESP_OKAY,
    default: '0
  };

  path_state_t q;
  path_state_t n;

  even_char_if ec ();

  even_char_logic u_even_char (
    .clk(SYS_CLK),
    .reset(RESET),
    .ec(ec)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Channel mapping

  logic [7:0] tape_channel_bits;

  for (genvar gi = 0; gi < 8; gi++) begin : g_chan
    assign tape_channel_bits[gi] = q.sync2[tape_rd_pkg::SI_LINES + 7 - gi];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Combinational next state

  logic read_mode;
  logic seven_track_select;
  logic nibble_pack;
  logic check_char_pass_enable;
  logic rd_evt;
  logic wr_evt;
  logic check_char_strobe;
  logic cyclic_check_strobe;
  logic char_read_strobe;
  logic buffer_low_load;
  logic buffer_high_load;
  logic [7:0] buffer_in;
  logic launch_pulse;
  logic wr_commit;
  logic wr_hit;
  logic [3:0] wr_word;
  logic [3:0] rd_word;
  logic req_evt;

  always_comb begin
    n = q;
    read_mode = q.ctrl[tape_rd_pkg::CTRL_READ_BIT];
    seven_track_select = q.ctrl[tape_rd_pkg::CTRL_SEVEN_BIT];
    nibble_pack = q.ctrl[tape_rd_pkg::CTRL_NIBBLE_BIT] & seven_track_select;
    check_char_pass_enable = q.ctrl[tape_rd_pkg::CTRL_CHK_PASS_BIT];
    launch_pulse = 1'b0;
    wr_commit = 1'b0;
    wr_hit = 1'b0;
    wr_word = {q.awaddr[3:2], 2'h0};
    rd_word = {S_AXI_ARADDR[3:2], 2'h0};

    n.sync1 = {TRANSPORT_READ_LINES, GENERAL_CLEAR, DMA_GRANT_IN, CHECK_CHAR_PARITY,
               CYCLIC_CHECK_STROBE, CHECK_CHAR_STROBE, TRANSPORT_WRITE_STROBE, TRANSPORT_READ_STROBE};
    n.sync2 = q.sync1;
    n.rd_prev = q.sync2[tape_rd_pkg::SI_RD];
    n.wr_prev = q.sync2[tape_rd_pkg::SI_WR];
    rd_evt = q.rd_prev & ~q.sync2[tape_rd_pkg::SI_RD];
    wr_evt = q.wr_prev & ~q.sync2[tape_rd_pkg::SI_WR];

    // Check strobes may drop before the read strobe does, so remember them per character
    check_char_strobe = q.chk_seen | q.sync2[tape_rd_pkg::SI_CHK];
    cyclic_check_strobe = q.crc_seen | q.sync2[tape_rd_pkg::SI_CRC];
    if (rd_evt) begin
      n.chk_seen = 1'b0;
      n.crc_seen = 1'b0;
    end else if (q.sync2[tape_rd_pkg::SI_RD]) begin
      n.chk_seen = check_char_strobe;
      n.crc_seen = cyclic_check_strobe;
    end

    // check character strobe suppressed unless passed
    char_read_strobe = rd_evt & read_mode & ~(check_char_strobe & ~check_char_pass_enable);

    if (char_read_strobe) begin
      n.select_read = 1'b1;
    end

    buffer_in = tape_channel_bits;
    // seven-track inhibits channels six and seven
    if (seven_track_select) begin
      buffer_in[7:6] = 2'h0;
    end
    // nibble-pack routes channels 0-3 to both halves
    if (nibble_pack) begin
      buffer_in[7:4] = tape_channel_bits[3:0];
    end

    // second nibble character withholds lower load
    buffer_low_load = char_read_strobe & (~nibble_pack | ec.pass);
    buffer_high_load = char_read_strobe;
    if (buffer_low_load) begin
      n.buffer[3:0] = buffer_in[3:0];
    end
    if (buffer_high_load) begin
      n.buffer[7:4] = buffer_in[7:4];
    end

    // parity taken from the check character
    if (read_mode & q.sync2[tape_rd_pkg::SI_CHK]) begin
      n.parity = q.sync2[tape_rd_pkg::SI_PAR];
    end

    // write strobes also drive the phase
    ec.enable = nibble_pack;
    ec.strobe_evt = char_read_strobe | (wr_evt & ~read_mode);

    req_evt = ((rd_evt & read_mode) | (wr_evt & ~read_mode)) & ~check_char_strobe & ~cyclic_check_strobe;
    // The phase settles one cycle after the strobe, so the request waits one cycle for it
    n.req_pend = req_evt;
    // nibble-pack requests only after even characters
    if (q.req_pend & ec.phase) begin
      n.dma_request = 1'b1;
    end else if (DMA_CYCLE_DONE) begin
      n.dma_request = 1'b0;
    end

    // byte lane chosen by address bit zero
    n.bus_oe = DMA_DATA_PHASE & DMA_MASTER_ACTIVE & read_mode;
    if (n.bus_oe) begin
      n.bus_data = MEM_ADDR_BIT0 ? {q.buffer, 8'h00} : {8'h00, q.buffer};
    end else begin
      n.bus_data = 16'h0000;
    end

    // AXI write: address and data taken in either order, answered once both are held
    if (S_AXI_AWVALID & ~q.aw_have & ~q.bvalid) begin
      n.aw_have = 1'b1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID & ~q.w_have & ~q.bvalid) begin
      n.w_have = 1'b1;
      n.wdata = S_AXI_WDATA;
      n.wstrb = S_AXI_WSTRB;
    end
    if (q.aw_have & q.w_have & ~q.bvalid) begin
      wr_commit = 1'b1;
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = tape_rd_pkg::RESP_OKAY;
    end else if (q.bvalid & S_AXI_BREADY) begin
      n.bvalid = 1'b0;
    end
    if (wr_commit) begin
      if (wr_word == tape_rd_pkg::CTRL_OFS) begin
        wr_hit = 1'b1;
        if (q.wstrb[0]) begin
          n.ctrl = q.wdata[tape_rd_pkg::CTRL_W-1:0];
        end
      end else if (wr_word == tape_rd_pkg::COMMAND_OFS) begin
        wr_hit = 1'b1;
        launch_pulse = q.wstrb[0] & q.wdata[tape_rd_pkg::CMD_LAUNCH_BIT];
      end else if (wr_word == tape_rd_pkg::STATUS_OFS) begin
        wr_hit = 1'b1;
      end else if (wr_word == tape_rd_pkg::BUFFER_OFS) begin
        wr_hit = 1'b1;
      end
      if (!wr_hit) begin
        n.bresp = tape_rd_pkg::RESP_SLVERR;
      end
    end

    // launch or general clear presets the phase logic
    ec.launch = launch_pulse | q.sync2[tape_rd_pkg::SI_CLR];
    if (ec.launch) begin
      n.select_read = 1'b0;
      n.req_pend = 1'b0;
      n.dma_request = 1'b0;
    end

    // AXI read: answered one cycle after the address is taken
    if (S_AXI_ARVALID & ~q.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = tape_rd_pkg::RESP_OKAY;
      n.rdata = '0;
      if (rd_word == tape_rd_pkg::CTRL_OFS) begin
        n.rdata[tape_rd_pkg::CTRL_W-1:0] = q.ctrl;
      end else if (rd_word == tape_rd_pkg::STATUS_OFS) begin
        n.rdata[tape_rd_pkg::ST_SELECT_READ_BIT] = q.select_read;
        n.rdata[tape_rd_pkg::ST_EVEN_PHASE_BIT] = ec.phase;
        n.rdata[tape_rd_pkg::ST_SWITCH_BIT] = ec.pass;
        n.rdata[tape_rd_pkg::ST_DMA_REQ_BIT] = q.dma_request;
        n.rdata[tape_rd_pkg::ST_PARITY_BIT] = q.parity;
      end else if (rd_word == tape_rd_pkg::BUFFER_OFS) begin
        // buffer in low byte, parity on bit 8
        n.rdata[tape_rd_pkg::BUF_W-1:0] = q.buffer;
        n.rdata[tape_rd_pkg::BUFFER_PARITY_BIT] = q.parity;
      end else if (rd_word == tape_rd_pkg::COMMAND_OFS) begin
        n.rdata = '0;
      end else begin
        n.rresp = tape_rd_pkg::RESP_SLVERR;
      end
    end else if (q.rvalid & S_AXI_RREADY) begin
      n.rvalid = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      q <= PATH_RESET;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign S_AXI_AWREADY = ~q.aw_have & ~q.bvalid;
  assign S_AXI_WREADY = ~q.w_have & ~q.bvalid;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_ARREADY = ~q.rvalid;
  assign S_AXI_RVALID = q.rvalid;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;

  assign DMA_REQUEST = q.dma_request;
  // grant passes when master or not requesting
  assign DMA_GRANT_OUT = q.sync2[tape_rd_pkg::SI_GRANT] & (DMA_MASTER_ACTIVE | ~q.dma_request);

  assign BUS_DATA = q.bus_data;
  assign BUS_DATA_OE = q.bus_oe;

endmodule

// ### verilog/tape_rd_pkg.sv
// Shared constants for the tape read byte assembly block
package tape_rd_pkg;

  // AXI4-Lite geometry
  localparam int AXI_ADDR_W = 4;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] BUFFER_OFS = 4'h8;
  localparam logic [3:0] COMMAND_OFS = 4'hc;

  // Control register fields
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int CTRL_READ_BIT = 0;
  localparam int CTRL_SEVEN_BIT = 1;
  localparam int CTRL_NIBBLE_BIT = 2;
  localparam int CTRL_CHK_PASS_BIT = 3;

  // Status register fields
  localparam int ST_SELECT_READ_BIT = 0;
  localparam int ST_EVEN_PHASE_BIT = 1;
  localparam int ST_SWITCH_BIT = 2;
  localparam int ST_DMA_REQ_BIT = 3;
  localparam int ST_PARITY_BIT = 4;

  // Command and buffer fields
  localparam int CMD_LAUNCH_BIT = 0;
  localparam int BUFFER_PARITY_BIT = 8;
  localparam int BUF_W = 8;

  // Positions of the pin inputs inside the synchroniser vector
  localparam int SI_RD = 0;
  localparam int SI_WR = 1;
  localparam int SI_CHK = 2;
  localparam int SI_CRC = 3;
  localparam int SI_PAR = 4;
  localparam int SI_GRANT = 5;
  localparam int SI_CLR = 6;
  localparam int SI_LINES = 7;
  localparam int SYNC_W = 15;

endpackage

// ### verilog/even_char_if.sv
// Link between the byte assembly path and its even-character logic
`timescale 1ns/1ps
interface even_char_if;
  logic strobe_evt;
  logic launch;
  logic enable;
  logic pass;
  logic phase;

  modport path (output strobe_evt, output launch, output enable, input pass, input phase);
  modport phase_logic (input strobe_evt, input launch, input enable, output pass, output phase);
endinterface

// ### verilog/even_char_logic.sv
// Even-character flip-flop and strobe switch flip-flop
`timescale 1ns/1ps
module even_char_logic (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Path side
  even_char_if.phase_logic ec
);

  typedef struct packed {
    logic even;
    logic sw;
  } ec_state_t;

  localparam ec_state_t EC_RESET = '{even: 1'b1, sw: 1'b1};

  ec_state_t q;
  ec_state_t n;

  always_comb begin
    n = q;
    if (ec.launch) begin
      n.even = 1'b1;
      n.sw = 1'b1;
    end else if (!ec.enable) begin
      n.even = 1'b1;
      n.sw = 1'b1;
    end else if (ec.strobe_evt) begin
      n.even = ~q.even;
      n.sw = ~q.even;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= EC_RESET;
    end else begin
      q <= n;
    end
  end

  assign ec.pass = q.sw;
  assign ec.phase = q.even;

endmodule

// ### tb/tape_xport_model.sv
// Behavioural tape transport driving read lines and strobes
`timescale 1ns/1ps
module tape_xport_model (
  // Clock
  input wire logic clk,
  // Transport pins
  output logic [7:0] lines,
  output logic rd_stb,
  output logic wr_stb,
  output logic chk_stb,
  output logic parity
);
  initial begin
    lines = 8'h5a;
    {rd_stb, wr_stb, chk_stb, parity} = 4'h0;
  end
  // One character frame; hi sets strobe width so prompt and slow tapes both occur
  task automatic send(input logic [7:0] v, input logic wr, input logic chk, input logic par, input int hi);
    @(posedge clk);
    lines <= v;
    chk_stb <= chk;
    parity <= par;
    @(posedge clk);
    rd_stb <= !wr;
    wr_stb <= wr;
    repeat (hi) @(posedge clk);
    {rd_stb, wr_stb} <= 2'h0;
    // Held past the synchroniser delay, then released so stale data cannot match
    repeat (6) @(posedge clk);
    lines <= ~v;
    chk_stb <= 1'h0;
    parity <= !par;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ### tb/tape_read_byte_assembly_chk.sv
// Port checker for the tape read byte assembly block
`timescale 1ns/1ps
module tape_read_byte_assembly_chk (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Register bus
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [tape_rd_pkg::AXI_DATA_W-1:0] S_AXI_RDATA,
  // Transport and DMA
  input wire logic TRANSPORT_READ_STROBE,
  input wire logic TRANSPORT_WRITE_STROBE,
  input wire logic DMA_GRANT_IN,
  input wire logic DMA_GRANT_OUT,
  input wire logic DMA_MASTER_ACTIVE,
  input wire logic DMA_DATA_PHASE,
  input wire logic MEM_ADDR_BIT0,
  input wire logic DMA_REQUEST,
  input wire logic [15:0] BUS_DATA,
  input wire logic BUS_DATA_OE
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////////////////////
  // Cycles since a strobe pin was last high, saturating
  logic [3:0] since_q;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET)
      since_q <= 4'hf;
    else if (TRANSPORT_READ_STROBE || TRANSPORT_WRITE_STROBE)
      since_q <= 4'h0;
    else if (since_q != 4'hf)
      since_q <= since_q + 4'h1;
  end
  ////////////////////////////////////////////////////////////////
  sequence s_bwait; S_AXI_BVALID && !S_AXI_BREADY; endsequence
  sequence s_rwait; S_AXI_RVALID && !S_AXI_RREADY; endsequence
  property p_grant_cond; DMA_GRANT_OUT |-> DMA_MASTER_ACTIVE || !DMA_REQUEST; endproperty
  a_grant_cond: assert property (p_grant_cond) else $error("grant passed while requesting");
  property p_grant_src; DMA_GRANT_OUT |-> $past(DMA_GRANT_IN, 2); endproperty
  a_grant_src: assert property (p_grant_src) else $error("grant out without grant in");
  property p_oe_cause; BUS_DATA_OE |-> $past(DMA_DATA_PHASE && DMA_MASTER_ACTIVE); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven outside data phase");
  property p_byte_sel; BUS_DATA_OE |-> ($past(MEM_ADDR_BIT0) ? BUS_DATA[7:0] : BUS_DATA[15:8]) == 8'h0; endproperty
  a_byte_sel: assert property (p_byte_sel) else $error("wrong byte lane driven");
  property p_b_hold; s_bwait |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_rwait |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_block; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address not answered or not blocked");
  property p_req_cause; $rose(DMA_REQUEST) |-> since_q inside {[3:12]}; endproperty
  a_req_cause: assert property (p_req_cause) else $error("request not tied to a strobe");
endmodule
bind tape_read_byte_assembly tape_read_byte_assembly_chk u_chk (.SYS_CLK, .RESET, .S_AXI_BVALID,
  .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA,
  .TRANSPORT_READ_STROBE, .TRANSPORT_WRITE_STROBE, .DMA_GRANT_IN, .DMA_GRANT_OUT, .DMA_MASTER_ACTIVE,
  .DMA_DATA_PHASE, .MEM_ADDR_BIT0, .DMA_REQUEST, .BUS_DATA, .BUS_DATA_OE);

// ### tb/tb_tape_read_byte_assembly.sv
// Self-checking bench for the tape read byte assembly block
`timescale 1ns/1ps
module tb_tape_read_byte_assembly;
  logic SYS_CLK, RESET, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [3:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [15:0] BUS_DATA;
  logic [7:0] TRANSPORT_READ_LINES, v, n1, n2, last;
  logic TRANSPORT_READ_STROBE, TRANSPORT_WRITE_STROBE, CHECK_CHAR_STROBE, CYCLIC_CHECK_STROBE;
  logic CHECK_CHAR_PARITY, GENERAL_CLEAR, DMA_GRANT_IN, DMA_GRANT_OUT, DMA_MASTER_ACTIVE;
  logic DMA_DATA_PHASE, DMA_CYCLE_DONE, MEM_ADDR_BIT0, DMA_REQUEST, BUS_DATA_OE;
  logic [3:0] md [3] = '{4'h1, 4'h3, 4'h5};
  int fails, tests_run;

  tape_read_byte_assembly u_tape_read_byte_assembly (.SYS_CLK, .RESET, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_AWADDR, .S_AXI_AWPROT(3'h0), .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_WDATA, .S_AXI_WSTRB(4'hf),
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_ARADDR,
    .S_AXI_ARPROT(3'h0), .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_RRESP, .TRANSPORT_READ_LINES,
    .TRANSPORT_READ_STROBE, .TRANSPORT_WRITE_STROBE, .CHECK_CHAR_STROBE, .CYCLIC_CHECK_STROBE,
    .CHECK_CHAR_PARITY, .GENERAL_CLEAR, .DMA_GRANT_IN, .DMA_GRANT_OUT, .DMA_MASTER_ACTIVE,
    .DMA_DATA_PHASE, .DMA_CYCLE_DONE, .MEM_ADDR_BIT0, .DMA_REQUEST, .BUS_DATA, .BUS_DATA_OE);
  tape_xport_model u_tape_xport_model (.clk(SYS_CLK), .lines(TRANSPORT_READ_LINES),
    .rd_stb(TRANSPORT_READ_STROBE), .wr_stb(TRANSPORT_WRITE_STROBE), .chk_stb(CHECK_CHAR_STROBE),
    .parity(CHECK_CHAR_PARITY));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Ready raised late on purpose so the slave has to hold its answer
  task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic [1:0] r);
    logic fin;
    fin = 0;
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= w;
    S_AXI_WVALID <= w;
    S_AXI_ARVALID <= !w;
    for (int n = 0; n < 40 && !fin; n++) begin
      @(posedge SYS_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 0;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
      if ((w ? S_AXI_BVALID && S_AXI_BREADY : S_AXI_RVALID && S_AXI_RREADY) === 1'b1) begin
        fin = 1;
        q = S_AXI_RDATA;
        r = w ? S_AXI_BRESP : S_AXI_RRESP;
        S_AXI_BREADY <= 0;
        S_AXI_RREADY <= 0;
      end else if (n == 2) begin
        S_AXI_BREADY <= w;
        S_AXI_RREADY <= !w;
      end
    end
    if (!fin) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0] r;
    axi(1, a, d, q, r);
    chk("bresp", 32'(r), 32'(tape_rd_pkg::RESP_OKAY));
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    logic [31:0] q;
    logic [1:0] r;
    axi(0, a, 0, q, r);
    chk("rresp", 32'(r), 32'(tape_rd_pkg::RESP_OKAY));
    chk(nm, q & m, e);
  endtask
  // Channel order is the reverse of the line order; seven-track drops the top pair
  function automatic logic [7:0] chan(input logic [7:0] l, input logic [3:0] m);
    logic [7:0] c;
    for (int i = 0; i < 8; i++) c[i] = l[7 - i];
    return m[1] ? {2'h0, c[5:0]} : c;
  endfunction
  task automatic dma(input logic a0, input logic [7:0] b);
    chk("grant_block", 32'(DMA_GRANT_OUT), 0);
    @(posedge SYS_CLK);
    DMA_MASTER_ACTIVE <= 1;
    DMA_DATA_PHASE <= 1;
    MEM_ADDR_BIT0 <= a0;
    @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    chk("bus", {DMA_GRANT_OUT, BUS_DATA_OE, BUS_DATA}, {2'h3, a0 ? {b, 8'h0} : {8'h0, b}});
    @(posedge SYS_CLK);
    DMA_DATA_PHASE <= 0;
    DMA_CYCLE_DONE <= 1;
    @(posedge SYS_CLK);
    DMA_CYCLE_DONE <= 0;
    DMA_MASTER_ACTIVE <= 0;
    repeat (3) @(posedge SYS_CLK);
    chk("req_done", {DMA_REQUEST, DMA_GRANT_OUT}, 2'h1);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    SYS_CLK = 0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 0;
    {CYCLIC_CHECK_STROBE, GENERAL_CLEAR, DMA_MASTER_ACTIVE, DMA_DATA_PHASE, DMA_CYCLE_DONE} = 0;
    MEM_ADDR_BIT0 = 0;
    DMA_GRANT_IN = 1;
    RESET = 1;
    fails = 0;
    tests_run = 0;
    void'($urandom(62));
    repeat (12) @(posedge SYS_CLK);
    RESET <= 0;
    repeat (4) @(posedge SYS_CLK);
    rd(tape_rd_pkg::CTRL_OFS, 32'hf, 32'h0, "ctrl_rst");
    rd(tape_rd_pkg::STATUS_OFS, 32'h1f, 32'h6, "status_rst");
    wr(tape_rd_pkg::STATUS_OFS, 32'hffff_ffff);
    rd(tape_rd_pkg::STATUS_OFS, 32'h1f, 32'h6, "status_ro");
    // Normal modes with prompt and slow strobes
    foreach (md[i]) for (int k = 0; k < 3; k++) begin
      wr(tape_rd_pkg::CTRL_OFS, 32'(md[i]));
      v = 8'($urandom);
      u_tape_xport_model.send(v, 0, 0, 0, 4 + 3 * k);
      last = chan(v, md[i]);
      rd(tape_rd_pkg::BUFFER_OFS, 32'hff, 32'(last), "buf");
      rd(tape_rd_pkg::STATUS_OFS, 32'hf, 32'hf, "status_rd");
      dma(k[0], last);
    end
    // Check characters never reach memory
    CYCLIC_CHECK_STROBE <= 1;
    v = 8'($urandom);
    u_tape_xport_model.send(v, 0, 0, 0, 4);
    CYCLIC_CHECK_STROBE <= 0;
    last = chan(v, 4'h5);
    chk("req_cyc", 32'(DMA_REQUEST), 0);
    wr(tape_rd_pkg::CTRL_OFS, 32'h1);
    u_tape_xport_model.send(8'($urandom), 0, 1, 1, 4);
    chk("req_chk", 32'(DMA_REQUEST), 0);
    rd(tape_rd_pkg::BUFFER_OFS, 32'h1ff, {23'h0, 1'b1, last}, "chk_blocked");
    wr(tape_rd_pkg::CTRL_OFS, 32'h9);
    v = 8'($urandom);
    u_tape_xport_model.send(v, 0, 1, 0, 5);
    chk("req_chk", 32'(DMA_REQUEST), 0);
    rd(tape_rd_pkg::BUFFER_OFS, 32'h1ff, 32'(chan(v, 4'h1)), "chk_pass");
    // Nibble pack assembly, then a clear in mid pair
    wr(tape_rd_pkg::CTRL_OFS, 32'h7);
    wr(tape_rd_pkg::COMMAND_OFS, 32'h1);
    for (int k = 0; k < 2; k++) begin
      v = 8'($urandom);
      u_tape_xport_model.send(v, 0, 0, 0, 4);
      n1 = chan(v, 4'h7);
      rd(tape_rd_pkg::BUFFER_OFS, 32'hff, 32'({n1[3:0], n1[3:0]}), "nib1");
      chk("nib_req1", 32'(DMA_REQUEST), 0);
      rd(tape_rd_pkg::STATUS_OFS, 32'h7, 32'h1, "nib_phase");
      if (k == 1) begin
        GENERAL_CLEAR <= 1;
        repeat (6) @(posedge SYS_CLK);
        GENERAL_CLEAR <= 0;
        repeat (4) @(posedge SYS_CLK);
        rd(tape_rd_pkg::STATUS_OFS, 32'hf, 32'h6, "clear");
      end else begin
        v = 8'($urandom);
        u_tape_xport_model.send(v, 0, 0, 0, 6);
        n2 = chan(v, 4'h7);
        last = {n2[3:0], n1[3:0]};
        rd(tape_rd_pkg::BUFFER_OFS, 32'hff, 32'(last), "nib2");
        rd(tape_rd_pkg::STATUS_OFS, 32'hf, 32'hf, "nib_req2");
        dma(1, last);
      end
    end
    // Write strobes toggle the phase; launch clears the DMA request raised by the second one
    wr(tape_rd_pkg::CTRL_OFS, 32'h6);
    wr(tape_rd_pkg::COMMAND_OFS, 32'h1);
    u_tape_xport_model.send(8'h0, 1, 0, 0, 4);
    rd(tape_rd_pkg::STATUS_OFS, 32'h6, 32'h0, "wr_phase0");
    u_tape_xport_model.send(8'hff, 1, 0, 0, 4);
    rd(tape_rd_pkg::STATUS_OFS, 32'h6, 32'h6, "wr_phase1");
    wr(tape_rd_pkg::COMMAND_OFS, 32'h1);
    rd(tape_rd_pkg::STATUS_OFS, 32'hf, 32'h6, "launch");
    // A grant that never arrived must not be passed on, even when idle
    DMA_GRANT_IN <= 0;
    repeat (4) @(posedge SYS_CLK);
    chk("grant_in_low", 32'(DMA_GRANT_OUT), 0);
    DMA_GRANT_IN <= 1;
    repeat (4) @(posedge SYS_CLK);
    chk("grant_in_high", 32'(DMA_GRANT_OUT), 1);
    tally_and_finish();
  end
endmodule
